// File: ltf_consts.vh
`ifndef LTF_CONSTS_VH
`define LTF_CONSTS_VH
// Configuration register field positions
`define LTF_RANGE_HI 15
`define LTF_RANGE_LO 12
`define LTF_CTIME_BIT 11
`define LTF_KIND_HI 10
`define LTF_KIND_LO 9
`define LTF_OVF_BIT 8
`define LTF_DONE_BIT 7
`define LTF_OVER_BIT 6
`define LTF_UNDER_BIT 5
`define LTF_STICKY_BIT 4
`define LTF_SENSE_BIT 3
`define LTF_MASK_BIT 2
`define LTF_RUN_HI 1
`define LTF_RUN_LO 0
// Conversion kinds
`define LTF_KIND_SHUTDOWN 2'h0
`define LTF_KIND_SINGLE 2'h1
// Range code that selects automatic ranging
`define LTF_RANGE_AUTO 4'hC
// Reset values of writable fields
`define LTF_RST_RANGE 4'hC
`define LTF_RST_CTIME 1'h1
`define LTF_RST_STICKY 1'h1
`define LTF_RST_SENSE 1'h0
`define LTF_RST_MASK 1'h0
`define LTF_RST_RUN 2'h0
// Result word layout
`define LTF_EXP_HI 15
`define LTF_EXP_LO 12
`define LTF_MANT_HI 11
`define LTF_MANT_LO 0
`define LTF_EXP_ZERO 4'h0
// Fault run counter width and terminal counts
`define LTF_CNT_W 3
`define LTF_RUN1 3'h0
`define LTF_RUN2 3'h1
`define LTF_RUN4 3'h3
`define LTF_RUN8 3'h7
`endif

// File: ltf_run_counter.v
`include "ltf_consts.vh"
// Counts consecutive fault measurements for one limit
module ltf_run_counter (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  // Measurement stream
  input wire meas_valid,
  input wire fault,
  input wire [`LTF_CNT_W-1:0] target,
  // Run reached on this measurement
  output wire run_met
);
  reg [`LTF_CNT_W-1:0] count_reg;
  reg [`LTF_CNT_W-1:0] count_next;

  assign run_met = meas_valid && fault && (count_reg >= target);

  // Saturate at target so a long run keeps reporting; non-fault restarts
  always @* begin
    count_next = count_reg;
    if (meas_valid) begin
      if (!fault)
        count_next = {`LTF_CNT_W{1'b0}}; // see RULE16
      else if (count_reg < target)
        count_next = count_reg + {{(`LTF_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Counter state
  always @(posedge sys_clk) begin
    if (sys_rst)
      count_reg <= {`LTF_CNT_W{1'b0}};
    else if (clk_en)
      count_reg <= count_next;
  end
endmodule

// File: ltf_flag_report.v
// What this block does
// RULE1 - Set conversion done flag when each conversion finishes.
// RULE2 - Clear done flag on config read, or on non-shutdown config write.
// RULE3 - Shutdown write leaves the done flag unchanged.
// RULE4 - Set over flag when result exceeds high limit for the run length.
// RULE5 - Set under flag when result is below low limit for run length.
// RULE6 - Transparent mode: alert and limit flags track comparisons, no clearing.
// RULE7 - Latched mode (reset): alert and flags hold until host clearing event.
// RULE8 - Sense 0 (reset): alert pin pulled low on an event.
// RULE9 - Sense 1: alert pin released high on an event.
// RULE10 - Mask on with manual range: reported exponent reads zero.
// RULE11 - Masking affects only result reads; comparisons use true result.
// RULE12 - Run length field: one, two, four or eight consecutive faults.
// RULE13 - Range code 1100b means automatic ranging, lower means manual.
// RULE14 - Entering shutdown preserves done flag, limit flags and alert.
// RULE15 - Single shot reads 01b while converting, then becomes shutdown.
// RULE16 - Fault run count restarts when a measurement is not a fault.
// RULE17 - Host reads the config register to clear latched alert and flags.
`include "ltf_consts.vh"
module ltf_flag_report (
  // Clock, reset, enable
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  // Register port from the serial bus engine
  input wire cfg_wr,
  input wire [15:0] cfg_wdata,
  input wire cfg_rd,
  output reg [15:0] cfg_rdata,
  // Measurement from the converter
  input wire conv_done,
  input wire [15:0] conv_result,
  input wire conv_overflow,
  // Limit registers
  input wire [15:0] low_limit,
  input wire [15:0] high_limit,
  // Reported result and alert pin (open drain)
  output reg [15:0] result_rdata,
  output reg alert_o,
  output reg alert_oe,
  // Converter control
  output reg conv_run,
  output reg conv_auto_range
);
  reg [3:0] range_reg;
  reg ctime_reg;
  reg [1:0] kind_reg;
  reg [1:0] kind_next;
  reg ovf_reg;
  reg done_reg;
  reg done_next;
  reg over_reg;
  reg over_next;
  reg under_reg;
  reg under_next;
  reg sticky_reg;
  reg sense_reg;
  reg mask_reg;
  reg [1:0] run_reg;
  reg [15:0] true_result_reg;
  reg [`LTF_CNT_W-1:0] run_target;
  wire over_fault;
  wire under_fault;
  wire over_met;
  wire under_met;
  wire alert_active;
  wire wr_active;
  wire take_meas;
  wire [15:0] true_result_next;
  wire [3:0] range_next;

  // Translate a float-style word to a comparable magnitude
  function [26:0] ltf_lux;
    input [15:0] w;
    begin
      ltf_lux = {15'h0000, w[`LTF_MANT_HI:`LTF_MANT_LO]} << w[`LTF_EXP_HI:`LTF_EXP_LO];
    end
  endfunction

  // Comparisons always use the unmasked result, see RULE11
  assign over_fault = ltf_lux(conv_result) > ltf_lux(high_limit); // see RULE4
  assign under_fault = ltf_lux(conv_result) < ltf_lux(low_limit); // see RULE5
  assign wr_active = cfg_wr && (cfg_wdata[`LTF_KIND_HI:`LTF_KIND_LO] != `LTF_KIND_SHUTDOWN);

  // A result that arrives while shut down is refused, so it must not feed the fault runs either
  assign take_meas = conv_done && (kind_reg != `LTF_KIND_SHUTDOWN);
  // Reported result and range follow the same edge as the flags, not one cycle later
  assign true_result_next = take_meas ? conv_result : true_result_reg;
  assign range_next = cfg_wr ? cfg_wdata[`LTF_RANGE_HI:`LTF_RANGE_LO] : range_reg;

  // Run length decode
  always @* begin
    case (run_reg)
      2'h0: run_target = `LTF_RUN1; // see RULE12
      2'h1: run_target = `LTF_RUN2;
      2'h2: run_target = `LTF_RUN4;
      default: run_target = `LTF_RUN8;
    endcase
  end

  ltf_run_counter u_over_run (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .meas_valid(take_meas),
    .fault(over_fault),
    .target(run_target),
    .run_met(over_met)
  );

  ltf_run_counter u_under_run (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .meas_valid(take_meas),
    .fault(under_fault),
    .target(run_target),
    .run_met(under_met)
  );

  // Flag and mode next state; a finishing conversion wins over a clear
  always @* begin
    done_next = done_reg;
    over_next = over_reg;
    under_next = under_reg;
    kind_next = kind_reg;
    if (cfg_rd || wr_active)
      done_next = 1'b0; // see RULE2
    // A shutdown write does not touch the flags, see RULE3 and RULE14
    if (sticky_reg && cfg_rd) begin
      over_next = 1'b0; // see RULE7
      under_next = 1'b0; // see RULE7
    end
    if (cfg_wr)
      kind_next = cfg_wdata[`LTF_KIND_HI:`LTF_KIND_LO];
    if (conv_done && kind_reg != `LTF_KIND_SHUTDOWN) begin
      done_next = 1'b1; // see RULE1
      if (kind_reg == `LTF_KIND_SINGLE && !cfg_wr)
        kind_next = `LTF_KIND_SHUTDOWN; // see RULE15
      if (sticky_reg) begin
        if (over_met)
          over_next = 1'b1; // see RULE7
        if (under_met)
          under_next = 1'b1;
      end else begin
        // Hysteresis: set on a full run, clear on the opposite run
        if (over_met)
          over_next = 1'b1; // see RULE6
        else if (under_met)
          over_next = 1'b0;
        if (under_met)
          under_next = 1'b1;
        else if (over_met)
          under_next = 1'b0;
      end
    end
  end

  assign alert_active = over_next || under_next;

  // Configuration and flag state
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      range_reg <= `LTF_RST_RANGE;
      ctime_reg <= `LTF_RST_CTIME;
      kind_reg <= `LTF_KIND_SHUTDOWN;
      ovf_reg <= 1'b0;
      done_reg <= 1'b0;
      over_reg <= 1'b0;
      under_reg <= 1'b0;
      sticky_reg <= `LTF_RST_STICKY;
      sense_reg <= `LTF_RST_SENSE;
      mask_reg <= `LTF_RST_MASK;
      run_reg <= `LTF_RST_RUN;
      true_result_reg <= 16'h0000;
    end else if (clk_en) begin
      done_reg <= done_next;
      over_reg <= over_next;
      under_reg <= under_next;
      kind_reg <= kind_next;
      if (cfg_wr) begin
        range_reg <= cfg_wdata[`LTF_RANGE_HI:`LTF_RANGE_LO];
        ctime_reg <= cfg_wdata[`LTF_CTIME_BIT];
        sticky_reg <= cfg_wdata[`LTF_STICKY_BIT];
        sense_reg <= cfg_wdata[`LTF_SENSE_BIT];
        mask_reg <= cfg_wdata[`LTF_MASK_BIT];
        run_reg <= cfg_wdata[`LTF_RUN_HI:`LTF_RUN_LO];
      end
      if (conv_done && kind_reg != `LTF_KIND_SHUTDOWN) begin
        ovf_reg <= conv_overflow;
        true_result_reg <= conv_result;
      end
    end
  end

  // Registered outputs, updated from next state so they match the flags
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_rdata <= 16'h0000;
      result_rdata <= 16'h0000;
      alert_o <= 1'b0;
      alert_oe <= 1'b0;
      conv_run <= 1'b0;
      conv_auto_range <= 1'b1;
    end else if (clk_en) begin
      cfg_rdata <= {range_reg, ctime_reg, kind_next, ovf_reg, done_next, over_next, under_next,
                    sticky_reg, sense_reg, mask_reg, run_reg};
      // Masking applies to the reported copy only, see RULE10
      if (mask_reg && range_reg < `LTF_RANGE_AUTO)
        result_rdata <= {`LTF_EXP_ZERO, true_result_next[`LTF_MANT_HI:`LTF_MANT_LO]};
      else
        result_rdata <= true_result_next;
      // Open drain: pull low when asserted low, release when asserted high
      alert_o <= 1'b0;
      alert_oe <= sense_reg ? !alert_active : alert_active; // see RULE8 RULE9
      conv_run <= kind_next != `LTF_KIND_SHUTDOWN;
      conv_auto_range <= range_next == `LTF_RANGE_AUTO; // see RULE13
    end
  end
endmodule

// File: ltf_props.sv
module ltf_props (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  input wire clk_en,
  // Register port
  input wire cfg_wr,
  input wire [15:0] cfg_wdata,
  input wire cfg_rd,
  input wire [15:0] cfg_rdata,
  // Measurement and outputs
  input wire conv_done,
  input wire [15:0] conv_result,
  input wire [15:0] result_rdata,
  input wire alert_oe,
  input wire conv_run,
  input wire conv_auto_range
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // A taken measurement with no host access in the same cycle
  sequence s_take; clk_en && conv_done && conv_run && !cfg_wr && !cfg_rd; endsequence
  sequence s_single; s_take ##0 cfg_rdata[10:9] == 2'h1; endsequence
  property p_done; s_take |=> cfg_rdata[7]; endproperty
  property p_rdclr; clk_en && cfg_rd && !conv_done && !cfg_wr |=> !cfg_rdata[7]; endproperty
  property p_sdkeep; clk_en && cfg_wr && cfg_wdata[10:9] == 2'h0 && !cfg_rd && !conv_done
    |=> $stable(cfg_rdata[7:5]); endproperty
  property p_single; s_single |=> cfg_rdata[10:9] == 2'h0 && !conv_run; endproperty
  property p_mask; s_take ##0 cfg_rdata[2] && cfg_rdata[15:12] < 4'hC
    |=> result_rdata == {4'h0, $past(conv_result[11:0])}; endproperty
  property p_nomask; s_take ##0 !cfg_rdata[2] |=> result_rdata == $past(conv_result); endproperty
  // Latched mode ties the pin to the flags; sense picks the level
  property p_senlo; cfg_rdata[4] && !cfg_rdata[3] |-> alert_oe == |cfg_rdata[6:5]; endproperty
  property p_senhi; cfg_rdata[4] && cfg_rdata[3] |-> alert_oe == !(|cfg_rdata[6:5]); endproperty
  property p_hold; clk_en && cfg_rdata[4] && cfg_rdata[6] && !cfg_rd && !cfg_wr |=> cfg_rdata[6]; endproperty
  property p_auto; clk_en && cfg_wr |=> conv_auto_range == ($past(cfg_wdata[15:12]) == 4'hC); endproperty
  a_done: assert property (p_done) else $error("done flag not set");
  a_rdclr: assert property (p_rdclr) else $error("done flag not cleared");
  a_sdkeep: assert property (p_sdkeep) else $error("shutdown write moved flags");
  a_single: assert property (p_single) else $error("single shot did not stop");
  a_mask: assert property (p_mask) else $error("exponent not masked");
  a_nomask: assert property (p_nomask) else $error("result altered");
  a_senlo: assert property (p_senlo) else $error("low sense pin wrong");
  a_senhi: assert property (p_senhi) else $error("high sense pin wrong");
  a_hold: assert property (p_hold) else $error("latched flag dropped");
  a_auto: assert property (p_auto) else $error("auto range wrong");
endmodule
bind ltf_flag_report ltf_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .conv_done(conv_done),
  .conv_result(conv_result), .result_rdata(result_rdata), .alert_oe(alert_oe), .conv_run(conv_run),
  .conv_auto_range(conv_auto_range));

// File: ltf_host.sv
module ltf_host (
  input wire sys_clk,
  output logic cfg_wr,
  output logic [15:0] cfg_wdata,
  output logic cfg_rd,
  input wire alert_o,
  input wire alert_oe,
  output wire alert_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // External pull-up wins whenever the device releases the pin
  assign alert_n = alert_oe ? alert_o : 1'b1;
  initial begin
    cfg_wr = 0;
    cfg_rd = 0;
    cfg_wdata = 0;
  end
  // Data is inverted after the write so a stale value is never seen
  task wr(input logic [15:0] d);
    @(posedge sys_clk) #1 cfg_wr = 1;
    cfg_wdata = d;
    @(posedge sys_clk) #1 cfg_wr = 0;
    cfg_wdata = ~d;
  endtask
  // A read is the clearing event of latched reporting
  task rd;
    @(posedge sys_clk) #1 cfg_rd = 1;
    @(posedge sys_clk) #1 cfg_rd = 0;
  endtask
endmodule

// File: test_light_threshold_flag_reporting.sv
module test_light_threshold_flag_reporting;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] HI = 16'h1200, MID = 16'h0080, LO = 16'h0001;
  logic sys_clk = 0, sys_rst = 1, clk_en = 1, conv_done = 0, conv_overflow = 0;
  logic [15:0] conv_result = 0, low_limit = 16'h0010, high_limit = 16'h0100;
  wire cfg_wr, cfg_rd, alert_o, alert_oe, alert_n, conv_run, conv_auto_range;
  wire [15:0] cfg_wdata, cfg_rdata, result_rdata;
  int bad_count = 0, checked = 0, cyc = 0;
  ltf_flag_report u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .cfg_wr(cfg_wr),
    .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd), .cfg_rdata(cfg_rdata), .conv_done(conv_done),
    .conv_result(conv_result), .conv_overflow(conv_overflow), .low_limit(low_limit), .high_limit(high_limit),
    .result_rdata(result_rdata), .alert_o(alert_o), .alert_oe(alert_oe), .conv_run(conv_run),
    .conv_auto_range(conv_auto_range));
  ltf_host u_host (.sys_clk(sys_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .cfg_rd(cfg_rd),
    .alert_o(alert_o), .alert_oe(alert_oe), .alert_n(alert_n));
  initial forever #5 sys_clk = ~sys_clk;
  // Hang guard, well above the roughly one hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      end_sim;
    end
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task end_sim;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function logic [15:0] mk(input logic [3:0] rg, input logic [1:0] k, input logic st, sn, ms, input logic [1:0] rn);
    mk = {rg, 1'b1, k, 4'h0, st, sn, ms, rn};
  endfunction
  task conv(input logic [15:0] r);
    @(posedge sys_clk) #1 conv_done = 1;
    conv_result = r;
    @(posedge sys_clk) #1 conv_done = 0;
    conv_result = ~r;
  endtask
  task t_single;
    u_host.wr(mk(4'hC, 2'h1, 1, 0, 0, 0));
    chk("kind", cfg_rdata[10:9], 2'h1);
    chk("run", conv_run, 1);
    conv(HI);
    chk("done", cfg_rdata[7], 1);
    chk("kind", cfg_rdata[10:9], 2'h0);
    chk("run", conv_run, 0);
    chk("over", cfg_rdata[6], 1);
    chk("pin", alert_n, 0);
    u_host.wr(mk(4'hC, 2'h0, 1, 0, 0, 0));
    chk("done", cfg_rdata[7], 1);
    chk("pin", alert_n, 0);
    u_host.rd;
    chk("done", cfg_rdata[7], 0);
    chk("pin", alert_n, 1);
  endtask
  task t_run;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(mk(4'hC, 2'h2, 1, 0, 0, i[1:0]));
      conv(MID);
      repeat ((1 << i) - 1) conv(HI);
      chk("over", cfg_rdata[6], 0);
      conv(HI);
      chk("over", cfg_rdata[6], 1);
      u_host.rd;
    end
    conv(MID);
    u_host.wr(mk(4'hC, 2'h2, 0, 0, 0, 0));
    chk("done", cfg_rdata[7], 0);
    conv(LO);
    chk("under", cfg_rdata[5], 1);
    conv(HI);
    chk("flags", cfg_rdata[6:5], 2'h2);
  endtask
  task t_mask;
    u_host.wr(mk(4'h3, 2'h2, 1, 1, 1, 0));
    chk("auto", conv_auto_range, 0);
    u_host.rd;
    chk("pin", alert_n, 0);
    conv(16'h5010);
    chk("result", result_rdata, 16'h0010);
    chk("over", cfg_rdata[6], 1);
    chk("pin", alert_n, 1);
    u_host.rd;
    chk("pin", alert_n, 0);
    u_host.wr(mk(4'h3, 2'h2, 1, 1, 0, 0));
    conv(16'h5010);
    chk("result", result_rdata, 16'h5010);
  endtask
  // A conversion that lands while the enable is low must leave the done flag alone
  task t_freeze;
    u_host.rd;
    @(posedge sys_clk) #1 clk_en = 0;
    conv(HI);
    chk("done", cfg_rdata[7], 0);
    clk_en = 1;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 sys_rst = 0;
    @(posedge sys_clk) #1;
    chk("config", cfg_rdata, 16'hC810);
    chk("pin", alert_n, 1);
    t_single;
    t_run;
    t_mask;
    t_freeze;
    end_sim;
  end
endmodule
